// ---- aoab_defines.svh ----
// constants of the acyclic object access bridge
`ifndef AOAB_DEFINES_SVH
`define AOAB_DEFINES_SVH
`define AOAB_DPV1_INDEX  8'h64
`define AOAB_HDR_BYTES   4'h8
`define AOAB_ACK_BYTES   5'h04
`define AOAB_BUF_DEPTH   16
`define AOAB_BUF_FULL    5'h10
`define AOAB_DATA_OVF    5'h11
`define AOAB_FIRST_SLOT  8'h02
`define AOAB_SLOT_OFFSET 8'h01
`define AOAB_ERR_NONE    32'h0000_0000
`define AOAB_ERR_DENIED  32'h0000_0701
`define AOAB_ERR_LENGTH  32'h0000_0705
`define AOAB_ERR_SLOT    32'h0000_0706
`define AOAB_CLK_KHZ     25000
`define AOAB_PULSE_MS    200
`define AOAB_FLASH_MS    500
`define AOAB_GAP_TICKS   4'h3
`define AOAB_PAUSE_TICKS 4'h8
`endif

// ---- aoab_pkg.sv ----
// types of the acyclic object access bridge
`default_nettype none
package aoab_pkg;
  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  subindex;
    logic        dir_write;
    logic [31:0] length;
    logic [7:0]  position;
  } aoab_req_t;

  typedef struct packed {
    logic run_green;
    logic run_blue;
    logic bus_fault_green;
    logic diag_red;
  } aoab_lamp_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_OBJ, ST_DONE, ST_TX} aoab_state_t;
  typedef enum logic [2:0] {D_OFF, D_PAUSE, D_CODE, D_GAP, D_LOC} aoab_dstate_t;
endpackage
`default_nettype wire

// ---- aoab_tick.sv ----
// free running timebase, one pulse every CYC clocks
`timescale 1ns/100ps
`default_nettype none
module aoab_tick #(
  parameter int unsigned CYC = 16
) (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  output logic      tick_o
);
  logic [31:0] cnt;
  wire         wrap = (cnt == 32'(CYC - 1));

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt    <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else begin
      cnt    <= wrap ? 32'h0000_0000 : cnt + 32'h0000_0001;
      tick_o <= wrap;
    end
  end
endmodule
`default_nettype wire

// ---- aoab_diag_seq.sv ----
// diagnostic lamp pulse sequencer: code burst, gap, location burst, pause
`timescale 1ns/100ps
`default_nettype none
`include "aoab_defines.svh"
module aoab_diag_seq (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       tick_i,
  input  wire logic       active_i,
  input  wire logic [3:0] code_i,
  input  wire logic [7:0] loc_i,
  output logic            red_o
);
  aoab_pkg::aoab_dstate_t state;
  logic [8:0] half;
  logic [3:0] code;
  logic [7:0] loc;
  // each pulse is one tick on and one tick off
  // a burst opens lit on its first tick and ends on the off tick of its last pulse
  wire        code_end = (half + 9'h002 == {4'h0, code, 1'b1});
  wire        loc_end  = (half + 9'h002 == {loc, 1'b1});
  wire        wait_end = (half[3:0] == `AOAB_PAUSE_TICKS);
  wire        gap_end  = (half[3:0] == `AOAB_GAP_TICKS);

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= aoab_pkg::D_OFF;
      half  <= 9'h000;
      code  <= 4'h0;
      loc   <= 8'h00;
      red_o <= 1'b0;
    end else if (!active_i) begin
      state <= aoab_pkg::D_OFF;
      half  <= 9'h000;
      red_o <= 1'b0;
    end else if (tick_i) begin
      half  <= half + 9'h001;
      red_o <= 1'b0;
      case (state)
        aoab_pkg::D_OFF, aoab_pkg::D_PAUSE: begin
          if (state == aoab_pkg::D_OFF || wait_end) begin
            // latched so a code change never splits a burst
            code  <= code_i;
            loc   <= loc_i;
            state <= aoab_pkg::D_CODE;
            half  <= 9'h000;
          end
        end
        aoab_pkg::D_CODE: begin
          red_o <= ~half[0] & ~code_end;
          if (code_end || code == 4'h0) begin
            state <= aoab_pkg::D_GAP;
            half  <= 9'h000;
            red_o <= 1'b0;
          end
        end
        aoab_pkg::D_GAP: begin
          if (gap_end) begin
            state <= aoab_pkg::D_LOC;
            half  <= 9'h000;
          end
        end
        aoab_pkg::D_LOC: begin
          red_o <= ~half[0] & ~loc_end;
          if (loc_end || loc == 8'h00) begin
            state <= aoab_pkg::D_PAUSE;
            half  <= 9'h000;
            red_o <= 1'b0;
          end
        end
        default: state <= aoab_pkg::D_OFF;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- aoab_bridge.sv ----
// acyclic object access bridge with status lamps
`timescale 1ns/100ps
`default_nettype none
`include "aoab_defines.svh"
// Summary of operation
// - access is one write then one read
// - read: write names object, read returns it
// - write: payload in write, result on read
// - write acknowledge is four zero bytes
// - failed write returns nonzero error code
// - header: index, subindex, direction, length
// - length counts payload; zero allowed on reads
// - dpv1 index 100, slot is position plus one
// - extra control/status modules take no slot
// - serve only when first slave enables dpv1
// - virtual slave dpv1 setting is ignored
// - only read-write objects complete an access
// - run lamp green started, blue update possible
// - bus fault lamp flashes idle, steady exchanging
// - pulse counts one to ten per fault
module aoab_bridge #(
  parameter int unsigned PULSE_CYC = `AOAB_PULSE_MS * `AOAB_CLK_KHZ,
  parameter int unsigned FLASH_CYC = `AOAB_FLASH_MS * `AOAB_CLK_KHZ
) (
  input  wire logic          mclk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          wr_start_i,
  input  wire logic [7:0]    wr_index_i,
  input  wire logic [7:0]    wr_slot_i,
  input  wire logic          wr_valid_i,
  input  wire logic [7:0]    wr_byte_i,
  input  wire logic          wr_end_i,
  input  wire logic          rd_req_i,
  output logic               rd_nak_o,
  output logic               rd_valid_o,
  output logic [7:0]         rd_byte_o,
  output logic               rd_last_o,
  input  wire logic          param_valid_i,
  input  wire logic [1:0]    param_slave_i,
  input  wire logic          param_dpv1_i,
  input  wire logic [7:0]    term_count_i,
  output aoab_pkg::aoab_req_t od_req_o,
  output logic               od_start_o,
  output logic               od_wr_valid_o,
  output logic [7:0]         od_wr_byte_o,
  input  wire logic          od_rd_valid_i,
  input  wire logic [7:0]    od_rd_byte_i,
  input  wire logic          od_done_i,
  input  wire logic          od_rw_ok_i,
  input  wire logic [31:0]   od_err_i,
  input  wire logic          started_i,
  input  wire logic          usb_update_i,
  input  wire logic          bus_comm_i,
  input  wire logic          data_exch_i,
  input  wire logic          err_active_i,
  input  wire logic [3:0]    err_code_i,
  input  wire logic [7:0]    err_loc_i,
  output aoab_pkg::aoab_lamp_t lamp_o
);
  aoab_pkg::aoab_state_t state;
  aoab_pkg::aoab_state_t next_state;
  aoab_pkg::aoab_req_t   req;
  logic [63:0] hdr;
  logic [3:0]  hcnt;
  logic [4:0]  dcnt;
  logic [4:0]  wcnt;
  logic [4:0]  rcnt;
  logic [4:0]  tcnt;
  logic [4:0]  tx_len;
  logic [7:0]  slot_q;
  logic [7:0]  index_q;
  logic        dpv1_en;
  logic [7:0]  buffer [0:`AOAB_BUF_DEPTH-1];
  logic        pulse_tick;
  logic        flash_tick;
  logic        flash;
  logic        diag_red;

  // header layout, most significant byte first
  assign req.index     = hdr[63:48];
  assign req.subindex  = hdr[47:40];
  assign req.dir_write = (hdr[39:32] != 8'h00);
  assign req.length    = hdr[31:0];
  assign req.position  = slot_q - `AOAB_SLOT_OFFSET;

  wire idx_ok  = (index_q == `AOAB_DPV1_INDEX);
  // positions count physical terminals only, so the control/status
  // module of each added virtual slave never shifts the numbering
  wire slot_ok = (slot_q >= `AOAB_FIRST_SLOT) &&
                 (req.position <= term_count_i);
  wire len_ok  = (req.length <= 32'(`AOAB_BUF_DEPTH)) &&
                 (req.length == 32'(dcnt));
  wire hdr_ok  = (hcnt == `AOAB_HDR_BYTES);
  wire [31:0] check_err =
      (!dpv1_en || !idx_ok)                ? `AOAB_ERR_DENIED :
      !slot_ok                             ? `AOAB_ERR_SLOT :
      (!hdr_ok || (req.dir_write && !len_ok)) ? `AOAB_ERR_LENGTH :
      `AOAB_ERR_NONE;
  wire [31:0] obj_err = !od_rw_ok_i ? `AOAB_ERR_DENIED : od_err_i;
  wire [31:0] next_result = (state == aoab_pkg::ST_RX) ? check_err : obj_err;
  wire go_done = (next_state == aoab_pkg::ST_DONE) && (state != aoab_pkg::ST_DONE);
  // a read of an empty object answers with an error rather than nothing
  wire empty_rd = !req.dir_write && (rcnt == 5'h00);
  wire [31:0] ack_code = (empty_rd && next_result == `AOAB_ERR_NONE) ?
                         `AOAB_ERR_LENGTH : next_result;
  wire ack_mode = req.dir_write || (next_result != `AOAB_ERR_NONE) || empty_rd;
  wire rx_hdr  = (state == aoab_pkg::ST_RX) && wr_valid_i && !hdr_ok;
  wire rx_data = (state == aoab_pkg::ST_RX) && wr_valid_i && hdr_ok;
  wire obj_wr  = (state == aoab_pkg::ST_OBJ) && req.dir_write &&
                 (32'(wcnt) < req.length);
  wire tx_end  = (tcnt == tx_len - 5'h01);

  assign rd_nak_o = rd_req_i && (state != aoab_pkg::ST_DONE);

  always_comb begin
    next_state = state;
    case (state)
      aoab_pkg::ST_IDLE: next_state = state;
      aoab_pkg::ST_RX: begin
        if (wr_end_i) begin
          next_state = (check_err == `AOAB_ERR_NONE) ? aoab_pkg::ST_OBJ :
                       aoab_pkg::ST_DONE;
        end
      end
      aoab_pkg::ST_OBJ: begin
        if (od_done_i) begin
          next_state = aoab_pkg::ST_DONE;
        end
      end
      aoab_pkg::ST_DONE: begin
        if (rd_req_i) begin
          next_state = aoab_pkg::ST_TX;
        end
      end
      aoab_pkg::ST_TX: begin
        if (tx_end) begin
          next_state = aoab_pkg::ST_IDLE;
        end
      end
      default: next_state = aoab_pkg::ST_IDLE;
    endcase
    if (wr_start_i) begin
      next_state = aoab_pkg::ST_RX;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= aoab_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // only the first slave's parameter data may switch the service
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dpv1_en <= 1'b0;
    end else if (param_valid_i && param_slave_i == 2'h0) begin
      dpv1_en <= param_dpv1_i;
    end
  end

  // telegram capture; a new write restarts everything
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hdr     <= 64'h0000_0000_0000_0000;
      hcnt    <= 4'h0;
      dcnt    <= 5'h00;
      slot_q  <= 8'h00;
      index_q <= 8'h00;
    end else if (wr_start_i) begin
      hcnt    <= 4'h0;
      dcnt    <= 5'h00;
      slot_q  <= wr_slot_i;
      index_q <= wr_index_i;
    end else if (rx_hdr) begin
      hdr  <= {hdr[55:0], wr_byte_i};
      hcnt <= hcnt + 4'h1;
    end else if (rx_data && dcnt != `AOAB_DATA_OVF) begin
      dcnt <= dcnt + 5'h01;
    end
  end

  // one buffer holds payload, fetched data or the acknowledge
  always_ff @(posedge mclk_i) begin
    if (rx_data && dcnt < `AOAB_BUF_FULL) begin
      buffer[dcnt[3:0]] <= wr_byte_i;
    end
    if (state == aoab_pkg::ST_OBJ && od_rd_valid_i && rcnt < `AOAB_BUF_FULL) begin
      buffer[rcnt[3:0]] <= od_rd_byte_i;
    end
    if (go_done && ack_mode) begin
      buffer[0] <= ack_code[31:24];
      buffer[1] <= ack_code[23:16];
      buffer[2] <= ack_code[15:8];
      buffer[3] <= ack_code[7:0];
    end
  end

  // object side: start pulse, payload stream, returned bytes
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      od_req_o      <= '0;
      od_start_o    <= 1'b0;
      od_wr_valid_o <= 1'b0;
      od_wr_byte_o  <= 8'h00;
      wcnt          <= 5'h00;
      rcnt          <= 5'h00;
    end else begin
      od_start_o    <= (next_state == aoab_pkg::ST_OBJ) && (state != aoab_pkg::ST_OBJ);
      od_wr_valid_o <= obj_wr;
      if (next_state == aoab_pkg::ST_OBJ && state != aoab_pkg::ST_OBJ) begin
        od_req_o <= req;
        wcnt     <= 5'h00;
        rcnt     <= 5'h00;
      end else if (state == aoab_pkg::ST_OBJ) begin
        if (obj_wr) begin
          od_wr_byte_o <= buffer[wcnt[3:0]];
          wcnt         <= wcnt + 5'h01;
        end
        if (od_rd_valid_i && rcnt < `AOAB_BUF_FULL) begin
          rcnt <= rcnt + 5'h01;
        end
      end
    end
  end

  // read answer, held until the next read arrives
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_len     <= 5'h00;
      tcnt       <= 5'h00;
      rd_valid_o <= 1'b0;
      rd_byte_o  <= 8'h00;
      rd_last_o  <= 1'b0;
    end else begin
      rd_valid_o <= (state == aoab_pkg::ST_TX);
      rd_last_o  <= (state == aoab_pkg::ST_TX) && tx_end;
      if (go_done) begin
        tx_len <= ack_mode ? `AOAB_ACK_BYTES : rcnt;
      end
      if (state == aoab_pkg::ST_TX) begin
        rd_byte_o <= buffer[tcnt[3:0]];
        tcnt      <= tcnt + 5'h01;
      end else begin
        tcnt <= 5'h00;
      end
    end
  end

  aoab_tick #(
    .CYC (PULSE_CYC)
  ) u_pulse_tick (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (pulse_tick)
  );

  aoab_tick #(
    .CYC (FLASH_CYC)
  ) u_flash_tick (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (flash_tick)
  );

  aoab_diag_seq u_diag (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (pulse_tick),
    .active_i  (err_active_i),
    .code_i    (err_code_i),
    .loc_i     (err_loc_i),
    .red_o     (diag_red)
  );

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flash  <= 1'b0;
      lamp_o <= '0;
    end else begin
      flash                  <= flash ^ flash_tick;
      lamp_o.run_green       <= started_i && !usb_update_i;
      lamp_o.run_blue        <= usb_update_i;
      // communicating but not yet exchanging leaves the lamp dark
      lamp_o.bus_fault_green <= data_exch_i || (!bus_comm_i && flash);
      lamp_o.diag_red        <= diag_red;
    end
  end
endmodule
`default_nettype wire

// ---- aoab_od_model.sv ----
// behavioural terminal object dictionary behind the bridge
`timescale 1ns/100ps
`default_nettype none
module aoab_od_model (
  input  wire logic                mclk_i,
  input  wire logic                sys_rst_i,
  input  wire aoab_pkg::aoab_req_t req_i,
  input  wire logic                start_i,
  input  wire logic                rw_ok_cfg_i,
  input  wire logic [3:0]          delay_i,
  output logic                     rd_valid_o,
  output logic [7:0]               rd_byte_o,
  output logic                     done_o,
  output logic                     rw_ok_o,
  output logic [31:0]              err_o
);
  logic       busy;
  logic [5:0] cnt;
  wire        rd_phase = busy && !req_i.dir_write && cnt < 6'h04;
  // writes finish only after the longest payload could have streamed in
  wire        fin = busy && cnt == (req_i.dir_write ? 6'h14 : 6'h04) + {2'h0, delay_i};
  assign rw_ok_o = rw_ok_cfg_i;
  assign err_o = 32'h0000_0000;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy <= 1'b0;
      cnt <= 6'h00;
      rd_valid_o <= 1'b0;
      rd_byte_o <= 8'h00;
      done_o <= 1'b0;
    end else begin
      busy <= start_i || (busy && !fin);
      cnt <= start_i ? 6'h00 : cnt + 6'h01;
      rd_valid_o <= rd_phase;
      // idle data wanders so a stale byte never looks valid
      rd_byte_o <= rd_phase ? req_i.index[7:0] + 8'(cnt) : ~rd_byte_o;
      done_o <= fin && !start_i;
    end
  end
endmodule
`default_nettype wire

// ---- aoab_bridge_asserts.sv ----
// port assertions for the acyclic object access bridge
`timescale 1ns/100ps
`default_nettype none
module aoab_bridge_asserts #(
  parameter int unsigned FLASH_CYC = 4
) (
  input wire logic                 mclk_i,
  input wire logic                 sys_rst_i,
  input wire logic                 wr_end_i,
  input wire logic                 rd_req_i,
  input wire logic                 rd_nak_o,
  input wire logic                 rd_valid_o,
  input wire logic                 rd_last_o,
  input wire aoab_pkg::aoab_req_t  od_req_o,
  input wire logic                 od_start_o,
  input wire logic                 od_wr_valid_o,
  input wire logic                 started_i,
  input wire logic                 usb_update_i,
  input wire logic                 bus_comm_i,
  input wire logic                 data_exch_i,
  input wire aoab_pkg::aoab_lamp_t lamp_o
);
  logic [4:0] wr_cnt;
  logic [7:0] stay;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_cnt <= 5'h00;
      stay <= 8'h00;
    end else begin
      wr_cnt <= od_start_o ? 5'h00 : wr_cnt + 5'(od_wr_valid_o);
      stay <= (!bus_comm_i && !data_exch_i && lamp_o.bus_fault_green
               == $past(lamp_o.bus_fault_green)) ? stay + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  property p_nak; rd_req_i && !rd_nak_o |=> !rd_req_i || rd_nak_o; endproperty
  a_nak: assert property (p_nak) else $error("second read not refused");
  property p_answer; rd_req_i && !rd_nak_o |-> ##[1:3] rd_valid_o; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_last; rd_last_o |-> rd_valid_o ##1 !rd_valid_o; endproperty
  a_last: assert property (p_last) else $error("last byte misplaced");
  property p_start; od_start_o |-> $past(wr_end_i); endproperty
  a_start: assert property (p_start) else $error("access without write end");
  property p_pulse; od_start_o |=> !od_start_o; endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_payload;
    od_wr_valid_o |-> od_req_o.dir_write && {27'h000_0000, wr_cnt} < od_req_o.length;
  endproperty
  a_payload: assert property (p_payload) else $error("payload beyond length");
  property p_green; (started_i && !usb_update_i) [*2] |-> lamp_o.run_green; endproperty
  a_green: assert property (p_green) else $error("run lamp not green");
  property p_blue; usb_update_i [*2] |-> lamp_o.run_blue && !lamp_o.run_green; endproperty
  a_blue: assert property (p_blue) else $error("run lamp not blue");
  property p_steady; data_exch_i [*2] |-> lamp_o.bus_fault_green; endproperty
  a_steady: assert property (p_steady) else $error("bus lamp not steady");
  property p_flash; stay < 8'(3 * FLASH_CYC); endproperty
  a_flash: assert property (p_flash) else $error("bus lamp not flashing");
  c_access: cover property (od_start_o);
  c_read: cover property (rd_last_o);
  c_diag: cover property ($rose(lamp_o.diag_red));
endmodule
bind aoab_bridge aoab_bridge_asserts #(.FLASH_CYC(FLASH_CYC)) u_chk (
  .mclk_i, .sys_rst_i, .wr_end_i, .rd_req_i, .rd_nak_o, .rd_valid_o, .rd_last_o, .od_req_o,
  .od_start_o, .od_wr_valid_o, .started_i, .usb_update_i, .bus_comm_i, .data_exch_i, .lamp_o);
`default_nettype wire

// ---- test_aoab_bridge.sv ----
// self-checking testbench of the acyclic object access bridge
`timescale 1ns/100ps
`default_nettype none
module test_aoab_bridge;
  logic                 mclk_i, sys_rst_i, wr_start_i, wr_valid_i, wr_end_i, rd_req_i;
  logic [7:0]           wr_index_i, wr_slot_i, wr_byte_i, rd_byte_o, term_count_i, err_loc_i;
  logic                 rd_nak_o, rd_valid_o, rd_last_o, param_valid_i, param_dpv1_i;
  logic [1:0]           param_slave_i;
  aoab_pkg::aoab_req_t  od_req_o;
  aoab_pkg::aoab_lamp_t lamp_o;
  logic                 od_start_o, od_wr_valid_o, od_rd_valid_i, od_done_i, od_rw_ok_i;
  logic [7:0]           od_wr_byte_o, od_rd_byte_i;
  logic [31:0]          od_err_i, pay;
  logic                 started_i, usb_update_i, bus_comm_i, data_exch_i, err_active_i;
  logic [3:0]           err_code_i, od_delay;
  logic                 rw_ok_cfg, prev;
  int                   miscompares, num_checks, cyc, n, code, loc;
  aoab_bridge #(.PULSE_CYC(4), .FLASH_CYC(4)) u_dut (
    .mclk_i, .sys_rst_i, .wr_start_i, .wr_index_i, .wr_slot_i, .wr_valid_i, .wr_byte_i,
    .wr_end_i, .rd_req_i, .rd_nak_o, .rd_valid_o, .rd_byte_o, .rd_last_o, .param_valid_i,
    .param_slave_i, .param_dpv1_i, .term_count_i, .od_req_o, .od_start_o, .od_wr_valid_o,
    .od_wr_byte_o, .od_rd_valid_i, .od_rd_byte_i, .od_done_i, .od_rw_ok_i, .od_err_i,
    .started_i, .usb_update_i, .bus_comm_i, .data_exch_i, .err_active_i, .err_code_i,
    .err_loc_i, .lamp_o);
  aoab_od_model u_od (.mclk_i, .sys_rst_i, .req_i(od_req_o), .start_i(od_start_o),
    .rw_ok_cfg_i(rw_ok_cfg), .delay_i(od_delay), .rd_valid_o(od_rd_valid_i),
    .rd_byte_o(od_rd_byte_i), .done_o(od_done_i), .rw_ok_o(od_rw_ok_i), .err_o(od_err_i));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  // payload bytes as the object side receives them
  always @(negedge mclk_i) begin
    if (od_wr_valid_o === 1'b1) begin
      pay <= {pay[23:0], od_wr_byte_o};
    end
  end
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic param(input logic [1:0] sl, input logic en);
    @(negedge mclk_i);
    {param_valid_i, param_slave_i, param_dpv1_i} = {1'b1, sl, en};
    @(negedge mclk_i);
    param_valid_i = 1'b0;
  endtask
  // header goes out big-endian: index, subindex, direction, length
  task automatic wr_tel(input logic [7:0] idx, input logic [7:0] slot, input logic [15:0] obj,
                        input logic dirw, input logic [31:0] len, input int npay);
    logic [63:0] h;
    h = {obj, 8'h03, 7'h00, dirw, len};
    @(negedge mclk_i);
    {wr_start_i, wr_index_i, wr_slot_i} = {1'b1, idx, slot};
    for (int i = 0; i < 8 + npay; i++) begin
      @(negedge mclk_i);
      {wr_start_i, wr_valid_i} = 2'b01;
      wr_byte_i = (i < 8) ? h[63 - 8 * i -: 8] : 8'(i);
    end
    @(negedge mclk_i);
    {wr_valid_i, wr_end_i} = 2'b01;
    @(negedge mclk_i);
    wr_end_i = 1'b0;
  endtask
  // the read is repeated while refused, as a master polls a busy slave
  task automatic rd_chk(input string what, input logic [31:0] exp, input int nb);
    logic [31:0] got;
    int          k;
    logic        fin;
    {got, k, fin} = '0;
    for (int t = 0; t < 60; t++) begin
      @(negedge mclk_i);
      rd_req_i = 1'b1;
      #1;
      if (rd_nak_o !== 1'b1) break;
    end
    for (int t = 0; t < 30 && !fin; t++) begin
      @(negedge mclk_i);
      rd_req_i = 1'b0;
      if (rd_valid_o === 1'b1) begin
        got = {got[23:0], rd_byte_o};
        k++;
        fin = rd_last_o;
      end
    end
    check({what, " count"}, 72'(k), 72'(nb));
    check(what, 72'(got), 72'(exp));
  endtask
  task automatic burst(input int gap, input int need, output int cnt);
    int off;
    {cnt, off} = '0;
    for (int t = 0; t < 400 && !(off >= gap && cnt >= need); t++) begin
      @(negedge mclk_i);
      cnt += (lamp_o.diag_red === 1'b1 && off > 0);
      off = (lamp_o.diag_red === 1'b1) ? 0 : off + 1;
    end
  endtask
  initial begin
    {wr_start_i, wr_index_i, wr_slot_i, wr_valid_i, wr_byte_i, wr_end_i, rd_req_i} = '0;
    {param_valid_i, param_slave_i, param_dpv1_i, started_i, usb_update_i} = '0;
    {bus_comm_i, data_exch_i, err_active_i, err_code_i, err_loc_i, od_delay} = '0;
    {sys_rst_i, rw_ok_cfg, term_count_i} = {2'b11, 8'h04};
    repeat (5) @(negedge mclk_i);
    check("lamps in reset", 72'(lamp_o), 72'h0);
    sys_rst_i = 1'b0;
    @(negedge mclk_i);
    rd_req_i = 1'b1;
    #1 check("nak when empty", 72'(rd_nak_o), 72'h1);
    @(negedge mclk_i);
    rd_req_i = 1'b0;
    param(2'h1, 1'b1);
    wr_tel(8'h64, 8'h02, 16'h6010, 1'b0, 32'h0, 0);
    rd_chk("virtual enable", 32'h0000_0701, 4);
    param(2'h0, 1'b1);
    wr_tel(8'h64, 8'h02, 16'h6010, 1'b0, 32'h0, 0);
    rd_chk("object read", 32'h1011_1213, 4);
    wr_tel(8'h64, 8'h05, 16'h7011, 1'b1, 32'h3, 3);
    check("request", 72'(od_req_o), {7'h00, 16'h7011, 8'h03, 1'b1, 32'h3, 8'h04});
    rd_chk("write ack", 32'h0, 4);
    check("payload", 72'(pay[23:0]), 72'h08_090a);
    wr_tel(8'h64, 8'h02, 16'h7012, 1'b1, 32'h10, 16);
    rd_chk("full payload", 32'h0, 4);
    check("full data", 72'(pay), 72'h1415_1617);
    od_delay = 4'h9;
    wr_tel(8'h64, 8'h02, 16'h6020, 1'b0, 32'h0, 0);
    wr_tel(8'h64, 8'h03, 16'h6030, 1'b0, 32'h0, 0);
    rd_chk("replaced", 32'h3031_3233, 4);
    {od_delay, rw_ok_cfg} = 5'h00;
    wr_tel(8'h64, 8'h02, 16'h7013, 1'b1, 32'h1, 1);
    rd_chk("denied", 32'h0000_0701, 4);
    rw_ok_cfg = 1'b1;
    wr_tel(8'h63, 8'h02, 16'h6010, 1'b0, 32'h0, 0);
    rd_chk("index", 32'h0000_0701, 4);
    wr_tel(8'h64, 8'h01, 16'h6010, 1'b0, 32'h0, 0);
    rd_chk("slot low", 32'h0000_0706, 4);
    wr_tel(8'h64, 8'h06, 16'h6010, 1'b0, 32'h0, 0);
    rd_chk("slot high", 32'h0000_0706, 4);
    wr_tel(8'h64, 8'h02, 16'h7014, 1'b1, 32'h3, 2);
    rd_chk("short data", 32'h0000_0705, 4);
    // restart: the service option and objects must be sent again
    sys_rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    wr_tel(8'h64, 8'h02, 16'h6010, 1'b0, 32'h0, 0);
    rd_chk("after restart", 32'h0000_0701, 4);
    param(2'h0, 1'b1);
    wr_tel(8'h64, 8'h02, 16'h6010, 1'b0, 32'h0, 0);
    rd_chk("resent", 32'h1011_1213, 4);
    {started_i, bus_comm_i} = 2'b11;
    repeat (3) @(negedge mclk_i);
    check("started", 72'(lamp_o), 72'h8);
    {usb_update_i, bus_comm_i, data_exch_i} = 3'b111;
    repeat (3) @(negedge mclk_i);
    check("update", 72'(lamp_o), 72'h6);
    {usb_update_i, bus_comm_i, data_exch_i} = 3'b000;
    n = 0;
    prev = lamp_o.bus_fault_green;
    repeat (24) begin
      @(negedge mclk_i);
      n += (lamp_o.bus_fault_green !== prev);
      prev = lamp_o.bus_fault_green;
    end
    check("flashing", 72'(n >= 4), 72'h1);
    for (int c = 1; c <= 10; c++) begin
      {err_code_i, err_loc_i, err_active_i} = {4'(c), 8'h02, 1'b1};
      burst(30, 0, n);
      burst(10, 1, code);
      burst(20, 1, loc);
      check("code pulses", 72'(code), 72'(c));
      check("location pulses", 72'(loc), 72'h2);
      burst(10, 1, code);
      check("repeat", 72'(code), 72'(c));
      err_active_i = 1'b0;
      repeat (200) @(negedge mclk_i);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
